// ==== rtl/mbrm_regs.svh ====
// Purpose: Register offsets, field positions, resets and timing counts
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register
// Notes: Image window serves one process-image byte per word
`ifndef MBRM_REGS_SVH
`define MBRM_REGS_SVH
// Register byte offsets
`define MBRM_CTRL_OFS 12'h000
`define MBRM_REQ_OFS 12'h004
`define MBRM_ITEM_OFS 12'h008
`define MBRM_TIME_OFS 12'h00C
`define MBRM_COIL_OFS 12'h010
`define MBRM_STAT_OFS 12'h014
`define MBRM_ISTAT_OFS 12'h018
`define MBRM_IMASK_OFS 12'h01C
`define MBRM_IMG_OFS 12'h100
// Field positions
`define MBRM_CTRL_RUN 0
`define MBRM_CTRL_TRIG 1
`define MBRM_CTRL_LEN 2
`define MBRM_IRQ_OK 0
`define MBRM_IRQ_TMO 1
`define MBRM_IRQ_BAD 2
// Reset value of every register
`define MBRM_RST_WORD 32'h0000_0000
// Protocol constants
`define MBRM_FC_COIL_RD 8'h01
`define MBRM_FC_INP_RD 8'h02
`define MBRM_FC_REG_RD 8'h03
`define MBRM_FC_IREG_RD 8'h04
`define MBRM_FC_COIL_WR 8'h05
`define MBRM_COIL_ON 16'hFF00
`define MBRM_CRC_INIT 16'hFFFF
`define MBRM_CRC_POLY 16'hA001
`define MBRM_REQ_LEN 4'h8
`define MBRM_STAGE_BASE 7'h40
`define MBRM_IMG_BYTES 7'h40
// One setting step of delay and timeout
`define MBRM_TICK_MS 10
`define MBRM_CLK_KHZ 10000
`define MBRM_TICK_CYCLES (`MBRM_TICK_MS * `MBRM_CLK_KHZ)
`endif

// ==== rtl/mbrm_pkg.sv ====
// Purpose: Types shared by the request mapper and its image memory
// Assumes: Constants live in mbrm_regs.svh
// Notes: State codes are Gray along idle, delay, send, wait, copy
package mbrm_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DELAY = 3'h1,
    ST_SEND = 3'h3,
    ST_WAIT = 3'h2,
    ST_COPY = 3'h6
  } mbrm_st_type;
  typedef struct packed {
    logic we;
    logic [6:0] waddr;
    logic [7:0] wdata;
    logic [6:0] raddr;
  } mbrm_ram_req_type;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } mbrm_byte_type;
  typedef struct packed {
    mbrm_st_type st;
    logic run, trig_en, len_en;
    logic [7:0] id, fc;
    logic [3:0] rep, retry, k;
    logic [15:0] idx, cnt, crc;
    logic [7:0] tmo, dly, coil, rx_n, rx_bc, ci, ticks, trig, len;
    logic [5:0] map;
    logic cph, hdr_bad;
    logic [19:0] tick;
    logic [25:0] aux;
    logic [2:0] istat, imask;
    logic irq;
    mbrm_byte_type tx;
    logic aw_got, w_got, awready, wready, arready, bvalid, rvalid;
    logic [11:0] aw_addr, ar_addr;
    logic [31:0] w_data, rdata;
    logic [3:0] w_strb;
    logic [1:0] bresp, rresp, rd_ph;
  } mbrm_state_type;
endpackage

// ==== rtl/mbrm_image_ram.sv ====
// Purpose: Process image and reply staging store, 128 bytes
// Assumes: One write and one read per cycle, enable freezes it
// Notes: Lower half is the image, upper half stages reply data
`timescale 1ns/1ps
module mbrm_image_ram (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // Access
  input wire mbrm_pkg::mbrm_ram_req_type req,
  output logic [7:0] rdata
);
  typedef struct packed {
    logic [127:0][7:0] mem;
    logic [7:0] rd;
  } mbrm_ram_st_type;
  mbrm_ram_st_type q, d;
  // Write and registered read
  always_comb begin
    d = q;
    if (ce) begin
      if (req.we) begin
        d.mem[req.waddr] = req.wdata;
      end
      d.rd = q.mem[req.raddr];
    end
  end
  // Image starts cleared
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign rdata = q.rd;
endmodule // mbrm_image_ram

// ==== rtl/mbrm_top.sv ====
// Purpose: Modbus RTU master request engine with process image
// Assumes: Request bytes move on valid/ready, reply bytes on valid alone; frame end is a pulse
// Notes: Config is read live; change it only while run is low
// Function
// - copy only configured item count
// - discrete inputs land at mapped byte, offset two
// - bits packed eight per byte, rounded up
// - length field grows with reply bytes
// - delay setting zero acts as one
// - eight byte request, CRC computed here
// - repeat zero sends request only once
// - wait at most timeout times 10ms, timeout zero acts as one
// - copy data only after valid reply
// - each register takes two image bytes
// - register high byte first, offset two
// - byte zero trigger, byte one length
// - start address sent raw, zero based
// - coil on when coil register nonzero
// - coil write ignores item count
// - trigger counter counts valid replies
// - length holds received character count
`timescale 1ns/1ps
`include "mbrm_regs.svh"
module mbrm_top #(
  parameter int TICK_CYCLES = `MBRM_TICK_CYCLES
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial byte link
  output mbrm_pkg::mbrm_byte_type tx,
  input wire logic tx_ready,
  input wire mbrm_pkg::mbrm_byte_type rx,
  input wire logic rx_frame_end,
  // Interrupt
  output logic irq
);
  mbrm_pkg::mbrm_state_type q, d;
  mbrm_pkg::mbrm_ram_req_type req;
  logic [7:0] ram_rdata;
  logic tick_hit;
  logic [15:0] nb;
  logic [7:0] dst;
  logic [2:0] ev, clr;
  logic rx_ok;

  // Bit reads take whole bytes, register reads two bytes each
  function automatic logic [15:0] exp_bytes(logic [7:0] fc,
                                           logic [15:0] cnt);
    if (fc == `MBRM_FC_COIL_RD || fc == `MBRM_FC_INP_RD) begin
      exp_bytes = 16'((17'(cnt) + 17'h0_0007) >> 3);
    end else begin
      exp_bytes = 16'(cnt << 1);
    end
  endfunction
  function automatic logic [7:0] at_least_one(logic [7:0] v);
    at_least_one = (v == 8'h00) ? 8'h01 : v;
  endfunction
  function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MBRM_CRC_POLY) : (r >> 1);
    end
    crc_step = r;
  endfunction
  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n,
                                        logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      o[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
    merge = o;
  endfunction
  // Request byte k; a coil write ignores the item count
  function automatic logic [7:0] frame_byte(mbrm_pkg::mbrm_state_type s);
    logic [15:0] val;
    val = (s.fc == `MBRM_FC_COIL_WR) ?
          ((s.coil != 8'h00) ? `MBRM_COIL_ON : 16'h0000) : s.cnt;
    case (s.k)
      4'h0: frame_byte = s.id;
      4'h1: frame_byte = s.fc;
      4'h2: frame_byte = s.idx[15:8];
      4'h3: frame_byte = s.idx[7:0];
      4'h4: frame_byte = val[15:8];
      4'h5: frame_byte = val[7:0];
      4'h6: frame_byte = s.crc[7:0];
      default: frame_byte = s.crc[15:8];
    endcase
  endfunction

  mbrm_image_ram u_ram (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .req(req),
    .rdata(ram_rdata)
  );

  assign tick_hit = (q.tick == 20'(TICK_CYCLES - 1));
  assign nb = exp_bytes(q.fc, q.cnt);
  assign dst = 8'(q.map) + 8'h02 + q.ci;
  // Reply is whole when CRC residue is zero and the size fits
  assign rx_ok = !q.hdr_bad && q.crc == 16'h0000 &&
                 ((q.fc == `MBRM_FC_COIL_WR) ? q.rx_n == 8'h08 :
                  (16'(q.rx_bc) == nb && q.rx_n == q.rx_bc + 8'h05));

  // Engine, register bus and interrupt state
  always_comb begin
    d = q;
    req = '0;
    ev = 3'h0;
    clr = 3'h0;
    if (ce) begin
      d.aux = (q.aux == '1) ? q.aux : q.aux + 26'h000_0001;
      d.tick = tick_hit ? 20'h0_0000 : q.tick + 20'h0_0001;
      case (q.st)
        mbrm_pkg::ST_IDLE: begin
          if (q.run) begin
            d.st = mbrm_pkg::ST_DELAY;
          end
        end
        // Pause between requests, never shorter than one step
        mbrm_pkg::ST_DELAY: begin
          if (!q.run) begin
            d.st = mbrm_pkg::ST_IDLE;
          end else if (tick_hit) begin
            d.ticks = q.ticks + 8'h01;
            if (q.ticks + 8'h01 >= at_least_one(q.dly)) begin
              d.st = mbrm_pkg::ST_SEND;
              d.retry = q.rep;
            end
          end
        end
        mbrm_pkg::ST_SEND: begin
          if (!q.tx.valid) begin
            d.tx.valid = 1'b1;
            d.tx.data = frame_byte(q);
          end else if (tx_ready) begin
            d.tx.valid = 1'b0;
            d.k = q.k + 4'h1;
            if (q.k < 4'h6) begin
              d.crc = crc_step(q.crc, q.tx.data);
            end
            if (q.k == `MBRM_REQ_LEN - 4'h1) begin
              d.st = mbrm_pkg::ST_WAIT;
            end
          end
        end
        // Collect the reply; staging keeps the image safe meanwhile
        mbrm_pkg::ST_WAIT: begin
          if (rx.valid) begin
            d.rx_n = q.rx_n + 8'h01;
            d.crc = crc_step(q.crc, rx.data);
            if ((q.rx_n == 8'h00 && rx.data != q.id) ||
                (q.rx_n == 8'h01 && rx.data != q.fc)) begin
              d.hdr_bad = 1'b1;
            end
            if (q.rx_n == 8'h02) begin
              d.rx_bc = rx.data;
            end
            if (q.rx_n >= 8'h03 && q.rx_n < 8'h43 &&
                q.fc != `MBRM_FC_COIL_WR) begin
              req.we = 1'b1;
              req.waddr = `MBRM_STAGE_BASE + 7'(q.rx_n - 8'h03);
              req.wdata = rx.data;
            end
          end else if (rx_frame_end) begin
            d.rx_n = 8'h00;
            d.hdr_bad = 1'b0;
            d.crc = `MBRM_CRC_INIT;
            if (rx_ok) begin
              ev[`MBRM_IRQ_OK] = 1'b1;
              if (q.trig_en) begin
                d.trig = q.trig + 8'h01;
              end
              if (q.len_en) begin
                d.len = q.rx_n;
              end
              d.st = (q.fc == `MBRM_FC_COIL_WR) ? mbrm_pkg::ST_DELAY :
                     mbrm_pkg::ST_COPY;
            end else begin
              ev[`MBRM_IRQ_BAD] = 1'b1;
            end
          end
          // Ticks run on while characters arrive, so traffic never
          // stretches the limit; a valid reply in this cycle wins
          if (tick_hit && d.st == mbrm_pkg::ST_WAIT) begin
            d.ticks = q.ticks + 8'h01;
            if (q.ticks + 8'h01 >= at_least_one(q.tmo)) begin
              ev[`MBRM_IRQ_TMO] = 1'b1;
              d.rx_n = 8'h00;
              d.hdr_bad = 1'b0;
              d.crc = `MBRM_CRC_INIT;
              if (q.retry != 4'h0) begin
                d.retry = q.retry - 4'h1;
                d.st = mbrm_pkg::ST_SEND;
              end else begin
                d.st = mbrm_pkg::ST_DELAY;
              end
            end
          end
        end
        // Move staged bytes, two cycles each, clipped to image end
        mbrm_pkg::ST_COPY: begin
          if (16'(q.ci) >= nb || q.ci >= 8'h40) begin
            d.st = mbrm_pkg::ST_DELAY;
          end else if (!q.cph) begin
            req.raddr = `MBRM_STAGE_BASE + 7'(q.ci);
            d.cph = 1'b1;
          end else begin
            d.cph = 1'b0;
            d.ci = q.ci + 8'h01;
            req.we = (dst < 8'(`MBRM_IMG_BYTES));
            req.waddr = 7'(dst);
            req.wdata = ram_rdata;
            if (nb == 16'(q.ci) + 16'h0001 && q.cnt[2:0] != 3'h0 &&
                (q.fc == `MBRM_FC_COIL_RD || q.fc == `MBRM_FC_INP_RD)) begin
              // Bits past the count read as zero
              req.wdata = ram_rdata & 8'((9'h001 << q.cnt[2:0]) - 9'h001);
            end
          end
        end
        default: d.st = mbrm_pkg::ST_IDLE;
      endcase
      // Fresh counters on every state change
      if (d.st != q.st) begin
        d.aux = 26'h000_0000;
        d.tick = 20'h0_0000;
        d.ticks = 8'h00;
        d.k = 4'h0;
        d.ci = 8'h00;
        d.cph = 1'b0;
        d.crc = `MBRM_CRC_INIT;
      end
      // Write address and data may come in either order
      if (s_axi_awvalid && q.awready) begin
        d.aw_got = 1'b1;
        d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready) begin
        d.w_got = 1'b1;
        d.w_data = s_axi_wdata;
        d.w_strb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready) begin
        d.bvalid = 1'b0;
      end
      if (q.aw_got && q.w_got && !q.bvalid) begin
        d.aw_got = 1'b0;
        d.w_got = 1'b0;
        d.bvalid = 1'b1;
        d.bresp = 2'h0;
        if (q.aw_addr == `MBRM_CTRL_OFS) begin
          {d.len_en, d.trig_en, d.run} = 3'(merge(
            {29'h0, q.len_en, q.trig_en, q.run}, q.w_data, q.w_strb));
        end else if (q.aw_addr == `MBRM_REQ_OFS) begin
          {d.rep, d.fc, d.id} = 20'(merge({12'h0, q.rep, q.fc, q.id},
                                          q.w_data, q.w_strb));
        end else if (q.aw_addr == `MBRM_ITEM_OFS) begin
          {d.cnt, d.idx} = merge({q.cnt, q.idx}, q.w_data, q.w_strb);
        end else if (q.aw_addr == `MBRM_TIME_OFS) begin
          {d.map, d.dly, d.tmo} = 22'(merge({10'h0, q.map, q.dly, q.tmo},
                                            q.w_data, q.w_strb));
        end else if (q.aw_addr == `MBRM_COIL_OFS) begin
          d.coil = 8'(merge({24'h0, q.coil}, q.w_data, q.w_strb));
        end else if (q.aw_addr == `MBRM_ISTAT_OFS) begin
          clr = q.w_strb[0] ? q.w_data[2:0] : 3'h0;
        end else if (q.aw_addr == `MBRM_IMASK_OFS) begin
          d.imask = 3'(merge({29'h0, q.imask}, q.w_data, q.w_strb));
        end else if (q.aw_addr != `MBRM_STAT_OFS &&
                     q.aw_addr[11:8] != 4'(`MBRM_IMG_OFS >> 8)) begin
          d.bresp = 2'h3;
        end
      end
      // Reads; image bytes wait while the engine owns the memory
      if (q.rvalid && s_axi_rready) begin
        d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && q.arready) begin
        d.ar_addr = s_axi_araddr;
        d.rd_ph = 2'h1;
      end
      if (q.rd_ph == 2'h2) begin
        d.rd_ph = 2'h0;
        d.rvalid = 1'b1;
        d.rdata = {24'h00_0000, ram_rdata};
      end else if (q.rd_ph == 2'h1) begin
        d.rresp = 2'h0;
        d.rdata = 32'h0000_0000;
        d.rd_ph = 2'h0;
        d.rvalid = 1'b1;
        if (q.ar_addr[11:8] == 4'(`MBRM_IMG_OFS >> 8)) begin
          if (q.ar_addr[7:2] == 6'h00) begin
            d.rdata[7:0] = q.trig;
          end else if (q.ar_addr[7:2] == 6'h01) begin
            d.rdata[7:0] = q.len;
          end else if (q.st != mbrm_pkg::ST_COPY) begin
            req.raddr = 7'(q.ar_addr[7:2]);
            d.rd_ph = 2'h2;
            d.rvalid = 1'b0;
          end else begin
            d.rd_ph = 2'h1;
            d.rvalid = 1'b0;
          end
        end else if (q.ar_addr == `MBRM_CTRL_OFS) begin
          d.rdata[2:0] = {q.len_en, q.trig_en, q.run};
        end else if (q.ar_addr == `MBRM_REQ_OFS) begin
          d.rdata[19:0] = {q.rep, q.fc, q.id};
        end else if (q.ar_addr == `MBRM_ITEM_OFS) begin
          d.rdata = {q.cnt, q.idx};
        end else if (q.ar_addr == `MBRM_TIME_OFS) begin
          d.rdata[21:0] = {q.map, q.dly, q.tmo};
        end else if (q.ar_addr == `MBRM_COIL_OFS) begin
          d.rdata[7:0] = q.coil;
        end else if (q.ar_addr == `MBRM_STAT_OFS) begin
          d.rdata = {q.retry, 1'b0, q.st, q.len, q.trig, q.rx_n};
        end else if (q.ar_addr == `MBRM_ISTAT_OFS) begin
          d.rdata[2:0] = q.istat;
        end else if (q.ar_addr == `MBRM_IMASK_OFS) begin
          d.rdata[2:0] = q.imask;
        end else begin
          d.rresp = 2'h3;
        end
      end
      // A new event beats a clear in the same cycle
      d.istat = (q.istat & ~clr) | ev;
      d.irq = |(d.istat & d.imask);
      d.awready = !d.aw_got && !d.bvalid;
      d.wready = !d.w_got && !d.bvalid;
      d.arready = d.rd_ph == 2'h0 && !d.rvalid;
    end
  end

  // Single state register; memory gets the same enable
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign tx = q.tx;
  assign irq = q.irq;

  // Checks on the engine
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  req_order_a: assert property (q.tx.valid && q.k == 4'h0 |->
    q.tx.data == q.id && q.st == mbrm_pkg::ST_SEND)
    else $error("first request byte is not the slave id");
  raw_index_a: assert property (q.tx.valid && q.k == 4'h3 |->
    q.tx.data == q.idx[7:0]) else $error("start address altered");
  coil_value_a: assert property (q.tx.valid && q.k == 4'h4 &&
    q.fc == `MBRM_FC_COIL_WR |-> q.tx.data == ((q.coil != 8'h00) ?
    8'hFF : 8'h00)) else $error("coil command value wrong");
  once_only_a: assert property (q.st == mbrm_pkg::ST_WAIT &&
    q.retry == 4'h0 ##1 q.st != mbrm_pkg::ST_WAIT |->
    q.st != mbrm_pkg::ST_SEND) else $error("request resent");
  delay_min_a: assert property (q.st == mbrm_pkg::ST_DELAY ##1
    q.st == mbrm_pkg::ST_SEND |-> $past(q.aux) >= 26'(TICK_CYCLES - 1))
    else $error("delay shorter than one step");
  wait_max_a: assert property (q.st == mbrm_pkg::ST_WAIT |->
    int'(q.aux) < int'(at_least_one(q.tmo)) * TICK_CYCLES)
    else $error("reply wait exceeded timeout");
  copy_cause_a: assert property (q.st == mbrm_pkg::ST_COPY &&
    $past(q.st) == mbrm_pkg::ST_WAIT |-> $past(rx_frame_end && rx_ok))
    else $error("copy without a valid reply");
  image_guard_a: assert property (req.we && req.waddr <
    `MBRM_IMG_BYTES |-> q.st == mbrm_pkg::ST_COPY && q.cph)
    else $error("image written outside copy");
  copy_bound_a: assert property (req.we && q.st ==
    mbrm_pkg::ST_COPY |-> 16'(q.ci) < nb) else $error("copy beyond count");
  trig_step_a: assert property (ce && q.st == mbrm_pkg::ST_WAIT &&
    rx_frame_end && !rx.valid && rx_ok && q.trig_en |=>
    q.trig == $past(q.trig) + 8'h01) else $error("trigger not counted");
  irq_level_a: assert property (ce |=> q.irq ==
    |(q.istat & q.imask)) else $error("interrupt level wrong");
  copy_done_c: cover property (q.st == mbrm_pkg::ST_COPY ##1
    q.st == mbrm_pkg::ST_DELAY);
  timeout_c: cover property (q.istat[`MBRM_IRQ_TMO]);
  bad_frame_c: cover property (q.istat[`MBRM_IRQ_BAD]);
endmodule // mbrm_top

// ==== dv/mbrm_slave_model.sv ====
// Purpose: Serial slave that answers read requests of the engine
// Assumes: Request is eight bytes; reply one character per cycle
// Notes: mute keeps it silent; pad sets spare bits to one
`timescale 1ns/1ps
module mbrm_slave_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Request bytes
  input wire mbrm_pkg::mbrm_byte_type tx,
  output logic tx_ready,
  // Reply characters
  output mbrm_pkg::mbrm_byte_type rx,
  output logic rx_frame_end,
  // Scenario controls
  input wire logic mute,
  input wire logic pad
);
  logic [7:0] req [0:7];
  int n_req;
  int frames;
  // One byte step of the frame check sum
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] b);
    int i;
    c = c ^ {8'h00, b};
    for (i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    return c;
  endfunction
  // Builds the reply from the captured request and sends it
  task automatic reply();
    logic [7:0] b [0:39];
    logic [15:0] a;
    logic [15:0] c;
    int cnt;
    int n;
    int k;
    a = {req[2], req[3]};
    cnt = int'({req[4], req[5]});
    b[0] = req[0];
    b[1] = req[1];
    if (req[1] == 8'h05) begin
      // Single coil write is answered by an echo of the request
      for (k = 3; k < 6; k++) b[k] = req[k];
      n = 3;
    end else if (req[1] > 8'h02) begin
      // Word at address x is {x low byte, A0 plus offset}
      n = 2 * cnt;
      for (k = 0; k < cnt; k++) begin
        b[3 + 2 * k] = a[7:0] + 8'(k);
        b[4 + 2 * k] = 8'hA0 + 8'(k);
      end
    end else begin
      // Odd addresses read one; spare bits are a hazard when padded
      n = (cnt + 7) / 8;
      for (k = 0; k < 8 * n; k++)
        b[3 + k / 8][k % 8] = (k < cnt) ? a[0] ^ k[0] : pad;
    end
    b[2] = (req[1] == 8'h05) ? req[2] : 8'(n);
    n = n + 3;
    c = 16'hFFFF;
    for (k = 0; k < n; k++) c = crc_step(c, b[k]);
    b[n] = c[7:0];
    b[n + 1] = c[15:8];
    repeat (3) @(posedge core_clk);
    for (k = 0; k < n + 2; k++) begin
      rx <= '{valid: 1'b1, data: b[k]};
      @(posedge core_clk);
    end
    // Idle line shows the inverse of the last character
    rx <= '{valid: 1'b0, data: ~b[n + 1]};
    @(posedge core_clk);
    rx_frame_end <= 1'b1;
    @(posedge core_clk);
    rx_frame_end <= 1'b0;
  endtask
  // Takes request bytes with a ready that toggles, for slow acceptance
  initial begin
    tx_ready = 1'b0;
    rx = '0;
    rx_frame_end = 1'b0;
    n_req = 0;
    frames = 0;
    forever begin
      @(posedge core_clk);
      if (rstn && tx.valid && tx_ready) begin
        req[n_req] = tx.data;
        n_req++;
      end
      tx_ready <= rstn & ~tx_ready;
      if (n_req == 8) begin
        n_req = 0;
        frames++;
        if (!mute) reply();
      end
    end
  end
endmodule // mbrm_slave_model

// ==== dv/tb_top.sv ====
// Purpose: Register-level tests of the request engine
// Assumes: Tick shortened to 20 cycles
// Notes: Each run stops the engine after the first interrupt
`timescale 1ns/1ps
`include "mbrm_regs.svh"
module tb_top;
  logic core_clk, rstn, ce, mute, pad, irq, tx_ready, rx_frame_end;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  mbrm_pkg::mbrm_byte_type tx, rx;
  int errors, tests_run, cyc, f0, t_req, t_irq;
  // Engine with a short tick and its serial partner
  mbrm_top #(.TICK_CYCLES(20)) dut (.core_clk, .rstn, .ce, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx,
    .tx_ready, .rx, .rx_frame_end, .irq);
  mbrm_slave_model slave (.core_clk, .rstn, .tx, .tx_ready, .rx,
    .rx_frame_end, .mute, .pad);
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Write: address and data together, then wait for the response
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    bit ad;
    bit dd;
    ad = 0;
    dd = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge core_clk);
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!dd && s_axi_wready === 1'b1) begin
        dd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [11:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic img(input int i, input logic [7:0] e);
    axr(12'(`MBRM_IMG_OFS + 4 * i), rd, rr);
    chk(rd, {24'h0, e});
  endtask
  // Request bytes as captured by the partner, check sum low byte first
  task automatic chk_req(input logic [47:0] e);
    logic [15:0] c;
    int k;
    c = 16'hFFFF;
    for (k = 0; k < 6; k++) c = slave.crc_step(c, e[47 - 8 * k -: 8]);
    chk({slave.req[0], slave.req[1], slave.req[2], slave.req[3]}, e[47:16]);
    chk({slave.req[4], slave.req[5], slave.req[7], slave.req[6]},
        {e[15:0], c});
  endtask
  // One run: configure, start, wait for the interrupt, stop
  task automatic run1(input logic [31:0] q, input logic [31:0] it,
                      input logic [31:0] tm);
    int n;
    axw(`MBRM_ISTAT_OFS, 32'h0000_0007);
    axw(`MBRM_REQ_OFS, q);
    axw(`MBRM_ITEM_OFS, it);
    axw(`MBRM_TIME_OFS, tm);
    axw(`MBRM_CTRL_OFS, 32'h0000_0007);
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    t_irq = cyc;
    chk({31'h0, irq}, 32'h1);
    axw(`MBRM_CTRL_OFS, 32'h0);
  endtask
  // Clock, cycle count, hang guard
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end
  always @(slave.frames) t_req = cyc;
  initial begin
    {rstn, mute, pad, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    ce = 1'b1;
    cyc = 0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    axr(`MBRM_CTRL_OFS, rd, rr);
    chk(rd, 32'h0);
    axr(12'h020, rd, rr);
    chk({30'h0, rr}, 32'h3);
    axw(12'h020, 32'h0000_0001);
    chk({30'h0, rr}, 32'h3);
    axw(`MBRM_IMASK_OFS, 32'h0000_0003);
    chk({30'h0, rr}, 32'h0);
    $display("test reset done");
    run1(32'h0000_0301, 32'h0002_0001, 32'h0000_0019);
    chk_req(48'h0103_0001_0002);
    img(0, 8'h01);
    img(1, 8'h09);
    img(2, 8'h01);
    img(3, 8'hA0);
    img(4, 8'h02);
    img(5, 8'hA1);
    img(6, 8'h00);
    $display("test registers done");
    pad <= 1'b1;
    run1(32'h0000_0201, 32'h000A_0006, 32'h0008_0019);
    chk_req(48'h0102_0006_000A);
    img(10, 8'hAA);
    img(11, 8'h02);
    img(12, 8'h00);
    img(1, 8'h07);
    img(0, 8'h02);
    $display("test bits done");
    mute <= 1'b1;
    f0 = slave.frames;
    run1(32'h0000_0301, 32'h0002_0001, 32'h0008_0001);
    chk(32'(slave.frames - f0), 32'h1);
    chk({31'h0, (t_irq - t_req) inside {[20:26]}}, 32'h1);
    img(10, 8'hAA);
    axr(`MBRM_ISTAT_OFS, rd, rr);
    chk(rd, 32'h2);
    $display("test timeout done");
    mute <= 1'b0;
    axw(`MBRM_COIL_OFS, 32'h0000_0003);
    run1(32'h0000_0501, 32'h0007_0005, 32'h0000_0001);
    chk_req(48'h0105_0005_FF00);
    img(1, 8'h08);
    img(0, 8'h03);
    axw(`MBRM_IMASK_OFS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    axw(`MBRM_ISTAT_OFS, 32'h0000_0007);
    axr(`MBRM_ISTAT_OFS, rd, rr);
    chk(rd, 32'h0);
    $display("test coil done");
    wrap_up();
  end
endmodule // tb_top
